// ==== verilog/sqsm_defines.svh ====
// register offsets, field positions, reset values and protocol codes
// for the qos, snooping and mirror control bank.
// assumes a word-addressed avalon-mm slave with one register per word.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`ifndef SQSM_DEFINES_SVH
`define SQSM_DEFINES_SVH

// register indices; byte address is four times the index
`define SQSM_IDX_MAP_3C    12'h35E
`define SQSM_IDX_MAP_3E    12'h35F
`define SQSM_IDX_GLOBAL    12'h370
`define SQSM_IDX_WRED      12'h378
`define SQSM_IDX_EVT_PRIO  12'h37C
`define SQSM_IDX_GEN_PRIO  12'h37D

// writable bit masks, reserved bits stay zero
`define SQSM_MASK_MAP      8'h77
`define SQSM_MASK_GLOBAL   8'h4D
`define SQSM_MASK_WRED     8'h3F
`define SQSM_MASK_PRIO     8'h8F

// reset values
`define SQSM_RST_MAP       8'h00
`define SQSM_RST_GLOBAL    8'h00
`define SQSM_RST_WRED      8'h39
`define SQSM_RST_PRIO      8'h0F

// field positions
`define SQSM_BIT_IGMP_EN   6
`define SQSM_BIT_CRITERIA  3
`define SQSM_BIT_MLD_EN    2
`define SQSM_BIT_MATCH_AND 0
`define SQSM_BIT_OVERRIDE  7

// field ranges inside the registers and the code point
`define SQSM_FLD_LO        2:0
`define SQSM_FLD_HI        6:4
`define SQSM_FLD_RED       5:4
`define SQSM_FLD_YELLOW    3:2
`define SQSM_FLD_GREEN     1:0
`define SQSM_FLD_PRIO      3:0
`define SQSM_FLD_DSCP_TOP  5:2
`define SQSM_BIT_DSCP_PAIR 1
`define SQSM_BIT_DSCP_ODD  0

// dscp code points served here
`define SQSM_DSCP_3C       6'h3C
`define SQSM_DSCP_3D       6'h3D
`define SQSM_DSCP_3E       6'h3E
`define SQSM_DSCP_3F       6'h3F
`define SQSM_DSCP_TOP      4'hF

// ip protocol and ipv6 next-header codes
`define SQSM_PROTO_IGMP    8'h02
`define SQSM_NH_HOPBYHOP   8'h00
`define SQSM_NH_ICMP       8'h01
`define SQSM_NH_ICMPV6     8'h3A
`define SQSM_NH_ROUTING    8'h2B
`define SQSM_NH_FRAGMENT   8'h2C
`define SQSM_NH_ESP        8'h32
`define SQSM_NH_AUTH       8'h33
`define SQSM_NH_DSTOPT     8'h3C

`endif

// ==== verilog/sqsm_pkg.sv ====
// shared types of the qos, snooping and mirror control bank.
// assumes sqsm_defines.svh carries every numeric constant.
package sqsm_pkg;
	// avalon slave answer state
	typedef enum logic {
		SQSM_BUS_IDLE,
		SQSM_BUS_ACK
	} sqsm_bus_e;
	// one byte-wide control register
	typedef logic [7:0] sqsm_byte_t;
endpackage : sqsm_pkg

// ==== verilog/sqsm_regs.sv ====
// global qos, snooping and mirror control registers with the
// per-packet classification logic they steer.
// assumes packet fields arrive synchronous to clk_i, one per pulse.
`timescale 1ns/1ps
`include "sqsm_defines.svh"

module sqsm_regs
	import sqsm_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// avalon-mm slave, word addressed
	input  wire logic [11:0] address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [3:0]  byteenable_i,
	input  wire logic [31:0] writedata_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	// packet descriptor in
	input  wire logic        pkt_valid_i,
	input  wire logic        pkt_ipv4_i,
	input  wire logic        pkt_ipv6_i,
	input  wire logic [5:0]  pkt_dscp_i,
	input  wire logic [7:0]  pkt_proto_i,
	input  wire logic [7:0]  pkt_hbh_next_i,
	input  wire logic        pkt_src_match_i,
	input  wire logic        pkt_dst_match_i,
	input  wire logic        pkt_ptp_event_i,
	input  wire logic        pkt_ptp_general_i,
	input  wire logic [3:0]  pkt_qos_prio_i,
	// classification result out
	output logic             res_valid_o,
	output logic             res_dscp_hit_o,
	output logic      [2:0]  res_dscp_prio_o,
	output logic             res_to_host_o,
	output logic             res_mirror_o,
	output logic      [3:0]  res_prio_o,
	// wred colour code points
	output logic      [1:0]  wred_red_o,
	output logic      [1:0]  wred_yellow_o,
	output logic      [1:0]  wred_green_o
);

	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	sqsm_byte_t map_3c_r;   // dscp 3c low, 3d high
	sqsm_byte_t map_3e_r;   // dscp 3e low, 3f high
	sqsm_byte_t global_r;   // snoop enables, criteria, match select
	sqsm_byte_t wred_r;     // red, yellow, green
	sqsm_byte_t evt_prio_r; // event override and priority
	sqsm_byte_t gen_prio_r; // general override and priority

	// ------------------------------------------------------------------
	// avalon-mm slave
	// ------------------------------------------------------------------
	sqsm_bus_e  bus_r;      // idle or answering
	logic       req;        // a request is presented
	logic       do_write;   // write takes effect this edge
	sqsm_byte_t wbyte;      // low lane of write data
	sqsm_byte_t rbyte_nxt;  // read mux result

	assign req      = read_i | write_i;
	assign wbyte    = writedata_i[7:0];
	// one wait cycle per request keeps the read mux off the bus path
	assign waitrequest_o = req & (bus_r != SQSM_BUS_ACK);
	assign do_write = write_i & (bus_r == SQSM_BUS_ACK)
		& byteenable_i[0];

	// answer state: ack exactly one cycle after the request shows
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bus_r <= SQSM_BUS_IDLE;
		end else begin
			case (bus_r)
				SQSM_BUS_IDLE: begin
					if (req) begin
						bus_r <= SQSM_BUS_ACK;
					end
				end
				SQSM_BUS_ACK: begin
					bus_r <= SQSM_BUS_IDLE;
				end
				default: begin
					bus_r <= SQSM_BUS_IDLE;
				end
			endcase
		end
	end

	// read mux; unmapped indices read zero
	always_comb begin
		case (address_i)
			`SQSM_IDX_MAP_3C:   rbyte_nxt = map_3c_r;
			`SQSM_IDX_MAP_3E:   rbyte_nxt = map_3e_r;
			`SQSM_IDX_GLOBAL:   rbyte_nxt = global_r;
			`SQSM_IDX_WRED:     rbyte_nxt = wred_r;
			`SQSM_IDX_EVT_PRIO: rbyte_nxt = evt_prio_r;
			`SQSM_IDX_GEN_PRIO: rbyte_nxt = gen_prio_r;
			default:            rbyte_nxt = 8'h00;
		endcase
	end

	// read data captured in the wait cycle, stands through the ack
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			readdata_o <= 32'h0000_0000;
		end else if (read_i && bus_r == SQSM_BUS_IDLE) begin
			readdata_o <= {24'h00_0000, rbyte_nxt};
		end
	end

	// ------------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------------
	// writes are masked so reserved bits can never be set
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			map_3c_r <= `SQSM_RST_MAP;
			map_3e_r <= `SQSM_RST_MAP;
		end else if (do_write) begin
			if (address_i == `SQSM_IDX_MAP_3C) begin
				map_3c_r <= wbyte & `SQSM_MASK_MAP;
			end
			if (address_i == `SQSM_IDX_MAP_3E) begin
				map_3e_r <= wbyte & `SQSM_MASK_MAP;
			end
		end
	end

	// global snooping and mirror control
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			global_r <= `SQSM_RST_GLOBAL;
		end else if (do_write && address_i == `SQSM_IDX_GLOBAL) begin
			global_r <= wbyte & `SQSM_MASK_GLOBAL;
		end
	end

	// wred colour values
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wred_r <= `SQSM_RST_WRED;
		end else if (do_write && address_i == `SQSM_IDX_WRED) begin
			wred_r <= wbyte & `SQSM_MASK_WRED;
		end
	end

	// timing message priority overrides
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			evt_prio_r <= `SQSM_RST_PRIO;
			gen_prio_r <= `SQSM_RST_PRIO;
		end else if (do_write) begin
			if (address_i == `SQSM_IDX_EVT_PRIO) begin
				evt_prio_r <= wbyte & `SQSM_MASK_PRIO;
			end
			if (address_i == `SQSM_IDX_GEN_PRIO) begin
				gen_prio_r <= wbyte & `SQSM_MASK_PRIO;
			end
		end
	end

	assign wred_red_o    = wred_r[`SQSM_FLD_RED];
	assign wred_yellow_o = wred_r[`SQSM_FLD_YELLOW];
	assign wred_green_o  = wred_r[`SQSM_FLD_GREEN];

	// ------------------------------------------------------------------
	// classification
	// ------------------------------------------------------------------
	logic       is_ip;      // ipv4 or ipv6 frame
	logic       dscp_hit;   // code point served by this bank
	sqsm_byte_t map_sel;    // register holding the pair
	logic [2:0] dscp_prio;  // looked-up priority
	logic       nh_v6set;   // criteria-set header match
	logic       hbh_v6set;  // same, behind hop-by-hop
	logic       nh_v6clr;   // criteria-clear header match
	logic       hbh_v6clr;  // same, behind hop-by-hop
	logic       is_hbh;     // next header is hop-by-hop
	logic       mld_pkt;    // snoopable ipv6 packet
	logic       igmp_pkt;   // ipv4 group management packet
	logic       to_host;    // redirect to host port
	logic       mirror;     // mirror this frame
	logic [3:0] prio;       // final queuing priority

	assign is_ip    = pkt_ipv4_i | pkt_ipv6_i;
	assign dscp_hit = is_ip
		& (pkt_dscp_i[`SQSM_FLD_DSCP_TOP] == `SQSM_DSCP_TOP);
	// pairs share one register: bit 1 picks the register
	assign map_sel  = pkt_dscp_i[`SQSM_BIT_DSCP_PAIR]
		? map_3e_r : map_3c_r;
	// even code point low field, odd code point high field
	assign dscp_prio = pkt_dscp_i[`SQSM_BIT_DSCP_ODD]
		? map_sel[`SQSM_FLD_HI]
		: map_sel[`SQSM_FLD_LO];

	// extension headers count when criteria bit is set
	function automatic logic nh_ext(input logic [7:0] nh);
		nh_ext = (nh == `SQSM_NH_ROUTING) | (nh == `SQSM_NH_FRAGMENT)
			| (nh == `SQSM_NH_ESP) | (nh == `SQSM_NH_AUTH)
			| (nh == `SQSM_NH_DSTOPT);
	endfunction

	// icmp headers count when criteria bit is clear
	function automatic logic nh_icmp(input logic [7:0] nh);
		nh_icmp = (nh == `SQSM_NH_ICMP) | (nh == `SQSM_NH_ICMPV6);
	endfunction

	assign is_hbh    = pkt_proto_i == `SQSM_NH_HOPBYHOP;
	assign nh_v6set  = nh_ext(pkt_proto_i);
	assign hbh_v6set = is_hbh & nh_ext(pkt_hbh_next_i);
	assign nh_v6clr  = nh_icmp(pkt_proto_i);
	assign hbh_v6clr = is_hbh & nh_icmp(pkt_hbh_next_i);
	assign mld_pkt   = pkt_ipv6_i & (global_r[`SQSM_BIT_CRITERIA]
		? (nh_v6set | hbh_v6set)
		: (nh_v6clr | hbh_v6clr));
	assign igmp_pkt  = pkt_ipv4_i & (pkt_proto_i == `SQSM_PROTO_IGMP);
	assign to_host   = (igmp_pkt & global_r[`SQSM_BIT_IGMP_EN])
		| (mld_pkt & global_r[`SQSM_BIT_MLD_EN]);

	// the per-port matches are the only source of mirroring; the global
	// bit only chooses how they combine
	assign mirror = global_r[`SQSM_BIT_MATCH_AND]
		? (pkt_src_match_i & pkt_dst_match_i)
		: (pkt_src_match_i | pkt_dst_match_i);

	// timing messages may bypass normal qos
	always_comb begin
		prio = pkt_qos_prio_i;
		if (pkt_ptp_event_i && evt_prio_r[`SQSM_BIT_OVERRIDE]) begin
			prio = evt_prio_r[`SQSM_FLD_PRIO];
		end else if (pkt_ptp_general_i
			&& gen_prio_r[`SQSM_BIT_OVERRIDE]) begin
			prio = gen_prio_r[`SQSM_FLD_PRIO];
		end
	end

	// result stage, one cycle after the descriptor
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			res_valid_o <= 1'b0;
		end else begin
			res_valid_o <= pkt_valid_i;
		end
	end

	// result fields hold the last packet until the next one
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			res_dscp_hit_o  <= 1'b0;
			res_dscp_prio_o <= 3'h0;
			res_to_host_o   <= 1'b0;
			res_mirror_o    <= 1'b0;
			res_prio_o      <= 4'h0;
		end else if (pkt_valid_i) begin
			res_dscp_hit_o  <= dscp_hit;
			res_dscp_prio_o <= dscp_hit ? dscp_prio : 3'h0;
			res_to_host_o   <= to_host;
			res_mirror_o    <= mirror;
			res_prio_o      <= prio;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence pkt_s;
		pkt_valid_i;
	endsequence

	sequence bus_wait_s;
		req && waitrequest_o;
	endsequence

	sequence bus_done_s;
		req && !waitrequest_o;
	endsequence

	bus_answer_a: assert property (
		bus_wait_s |=> bus_done_s)
		else $error("bus answer not one cycle after request");

	rsvd_read_a: assert property (
		read_i && !waitrequest_o |-> readdata_o[31:8] == 24'h0
			&& (address_i != `SQSM_IDX_GLOBAL
			|| (readdata_o[7:0] & ~`SQSM_MASK_GLOBAL) == 8'h00))
		else $error("reserved read bits not zero");

	dscp_low_a: assert property (
		pkt_s ##0 (is_ip && pkt_dscp_i == `SQSM_DSCP_3C)
		|=> res_dscp_hit_o
			&& res_dscp_prio_o == $past(map_3c_r[`SQSM_FLD_LO]))
		else $error("dscp 3c priority wrong");

	dscp_high_a: assert property (
		pkt_s ##0 (is_ip && pkt_dscp_i == `SQSM_DSCP_3F)
		|=> res_dscp_prio_o == $past(map_3e_r[`SQSM_FLD_HI]))
		else $error("dscp 3f priority wrong");

	igmp_host_a: assert property (
		pkt_s ##0 igmp_pkt
		|=> res_to_host_o == $past(global_r[`SQSM_BIT_IGMP_EN]))
		else $error("igmp redirect wrong");

	mld_icmp_a: assert property (
		pkt_s ##0 (pkt_ipv6_i && pkt_proto_i == `SQSM_NH_ICMPV6
			&& global_r[`SQSM_BIT_MLD_EN]
			&& !global_r[`SQSM_BIT_CRITERIA])
		|=> res_to_host_o)
		else $error("mld icmpv6 not redirected");

	mld_ext_a: assert property (
		pkt_s ##0 (pkt_ipv6_i && is_hbh
			&& pkt_hbh_next_i == `SQSM_NH_FRAGMENT
			&& global_r[`SQSM_BIT_MLD_EN]
			&& global_r[`SQSM_BIT_CRITERIA])
		|=> res_to_host_o)
		else $error("mld extension header not redirected");

	mld_off_a: assert property (
		pkt_s ##0 (!global_r[`SQSM_BIT_MLD_EN] && !pkt_ipv4_i)
		|=> !res_to_host_o)
		else $error("ipv6 redirect while disabled");

	mirror_mode_a: assert property (
		pkt_s ##0 (pkt_src_match_i != pkt_dst_match_i)
		|=> res_mirror_o == !$past(global_r[`SQSM_BIT_MATCH_AND]))
		else $error("mirror match select wrong");

	mirror_need_a: assert property (
		pkt_s ##0 (!pkt_src_match_i && !pkt_dst_match_i)
		|=> !res_mirror_o)
		else $error("mirror without port match");

	ptp_event_a: assert property (
		pkt_s ##0 (pkt_ptp_event_i && evt_prio_r[`SQSM_BIT_OVERRIDE])
		|=> res_prio_o == $past(evt_prio_r[`SQSM_FLD_PRIO]))
		else $error("event message priority not forced");

	ptp_general_a: assert property (
		pkt_s ##0 (pkt_ptp_general_i && !pkt_ptp_event_i
			&& !gen_prio_r[`SQSM_BIT_OVERRIDE])
		|=> res_prio_o == $past(pkt_qos_prio_i))
		else $error("general message priority altered");

	wred_rst_a: assert property (
		$rose(arst_n_i) |-> wred_red_o == 2'h3
			&& wred_yellow_o == 2'h2 && wred_green_o == 2'h1)
		else $error("wred colours not at reset value");

endmodule : sqsm_regs

// ==== verif/tb_sqsm_regs.sv ====
// self-checking bench for the qos, snooping and mirror control bank.
// assumes sqsm_defines.svh on the include path and one 100 mhz clock.
`timescale 1ns/1ps
`include "sqsm_defines.svh"

module tb_sqsm_regs;
	import sqsm_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk_i, arst_n_i;            // clock and async reset
	logic [11:0] address_i;                  // word address
	logic        read_i, write_i;            // bus requests
	logic [3:0]  byteenable_i;               // lane enables
	logic [31:0] writedata_i, readdata_o;    // bus data
	logic        waitrequest_o;              // slave stall
	logic        pkt_valid_i, pkt_ipv4_i, pkt_ipv6_i;
	logic [5:0]  pkt_dscp_i;                 // code point
	logic [7:0]  pkt_proto_i, pkt_hbh_next_i;
	logic        pkt_src_match_i, pkt_dst_match_i;
	logic        pkt_ptp_event_i, pkt_ptp_general_i;
	logic [3:0]  pkt_qos_prio_i, res_prio_o;
	logic        res_valid_o, res_dscp_hit_o, res_to_host_o, res_mirror_o;
	logic [2:0]  res_dscp_prio_o;            // mapped priority
	logic [1:0]  wred_red_o, wred_yellow_o, wred_green_o;
	int          fail_count, compares;       // report counters
	logic [31:0] rd_v;                       // last read value

	sqsm_regs sqsm_regs_inst (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i),
		.byteenable_i(byteenable_i), .writedata_i(writedata_i),
		.readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.pkt_valid_i(pkt_valid_i), .pkt_ipv4_i(pkt_ipv4_i),
		.pkt_ipv6_i(pkt_ipv6_i), .pkt_dscp_i(pkt_dscp_i),
		.pkt_proto_i(pkt_proto_i), .pkt_hbh_next_i(pkt_hbh_next_i),
		.pkt_src_match_i(pkt_src_match_i),
		.pkt_dst_match_i(pkt_dst_match_i),
		.pkt_ptp_event_i(pkt_ptp_event_i),
		.pkt_ptp_general_i(pkt_ptp_general_i),
		.pkt_qos_prio_i(pkt_qos_prio_i),
		.res_valid_o(res_valid_o), .res_dscp_hit_o(res_dscp_hit_o),
		.res_dscp_prio_o(res_dscp_prio_o),
		.res_to_host_o(res_to_host_o), .res_mirror_o(res_mirror_o),
		.res_prio_o(res_prio_o), .wred_red_o(wred_red_o),
		.wred_yellow_o(wred_yellow_o), .wred_green_o(wred_green_o)
	);

	// free-running clock, 10 ns period
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	// verdict and end of run, also reached from a hung wait
	task test_done;
		$display("fail_count %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one comparison, four-state exact
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	// waitrequest is sampled at the rising edge it qualifies, before
	// the design's own updates of that edge land
	task ack;
		int n;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (waitrequest_o === 1'b0)
				break;
		end
		if (n == 20) begin
			fail_count++;
			$display("unexpected waitrequest expected 0 seen 1");
			test_done;
		end
	endtask

	// write held until the accepting edge, then released
	task wr(input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] be = 4'hF);
		address_i <= a;
		writedata_i <= {24'h0, d};
		byteenable_i <= be;
		write_i <= 1'b1;
		ack;
		write_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// read and compare the whole word, upper bits included
	task rd(input logic [11:0] a, input logic [7:0] e, input string n);
		address_i <= a;
		read_i <= 1'b1;
		ack;
		rd_v = readdata_o;
		read_i <= 1'b0;
		@(posedge clk_i);
		chk(n, {24'h0, e}, rd_v);
	endtask

	// one descriptor; ipv6 whenever not ipv4
	task pk(input logic v4, input logic [7:0] nh, input logic [7:0] hb,
		input logic [5:0] ds);
		pkt_ipv4_i <= v4;
		pkt_ipv6_i <= ~v4;
		pkt_proto_i <= nh;
		pkt_hbh_next_i <= hb;
		pkt_dscp_i <= ds;
		pkt_valid_i <= 1'b1;
		@(posedge clk_i);
		pkt_valid_i <= 1'b0;
		@(negedge clk_i);
		chk("res_valid", 1, res_valid_o);
		@(posedge clk_i);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reset contents and colour outputs
	task t_reset;
		rd(`SQSM_IDX_MAP_3C, 8'h00, "map3c");
		rd(`SQSM_IDX_MAP_3E, 8'h00, "map3e");
		rd(`SQSM_IDX_GLOBAL, 8'h00, "global");
		rd(`SQSM_IDX_WRED, 8'h39, "wred");
		rd(`SQSM_IDX_EVT_PRIO, 8'h0F, "evt");
		rd(`SQSM_IDX_GEN_PRIO, 8'h0F, "gen");
		chk("wred_out", 6'h39, {wred_red_o, wred_yellow_o, wred_green_o});
	endtask

	// all ones written: only documented fields stick
	task t_regs;
		wr(`SQSM_IDX_MAP_3C, 8'hFF);
		rd(`SQSM_IDX_MAP_3C, 8'h77, "map3c_rsv");
		wr(`SQSM_IDX_MAP_3E, 8'hFF);
		rd(`SQSM_IDX_MAP_3E, 8'h77, "map3e_rsv");
		wr(`SQSM_IDX_GLOBAL, 8'hFF);
		rd(`SQSM_IDX_GLOBAL, 8'h4D, "global_rsv");
		wr(`SQSM_IDX_WRED, 8'hFF);
		rd(`SQSM_IDX_WRED, 8'h3F, "wred_rsv");
		wr(`SQSM_IDX_EVT_PRIO, 8'hFF);
		rd(`SQSM_IDX_EVT_PRIO, 8'h8F, "evt_rsv");
		wr(`SQSM_IDX_GEN_PRIO, 8'hFF);
		rd(`SQSM_IDX_GEN_PRIO, 8'h8F, "gen_rsv");
		// low lane disabled: write must not land
		wr(`SQSM_IDX_GLOBAL, 8'h00, 4'hE);
		rd(`SQSM_IDX_GLOBAL, 8'h4D, "global_be");
		wr(12'h371, 8'hFF);
		rd(12'h371, 8'h00, "unmapped");
		wr(`SQSM_IDX_WRED, 8'h1B);
		chk("wred_new", 6'h1B, {wred_red_o, wred_yellow_o, wred_green_o});
	endtask

	// four top code points, even low field, odd high field
	task t_dscp;
		logic [2:0] e [4];
		e = '{3'd2, 3'd5, 3'd3, 3'd6};
		wr(`SQSM_IDX_MAP_3C, 8'h52);
		wr(`SQSM_IDX_MAP_3E, 8'h63);
		for (int i = 0; i < 4; i++) begin
			pk(i[0], 8'h06, 8'h00, 6'h3C + 6'(i));
			chk("dscp_hit", 1, res_dscp_hit_o);
			chk("dscp_prio", e[i], res_dscp_prio_o);
		end
		pk(1'b1, 8'h06, 8'h00, 6'h3B);
		chk("dscp_miss", 4'h0, {res_dscp_hit_o, res_dscp_prio_o});
	endtask

	// snooping to host under each enable and criteria setting
	task t_snoop;
		logic [7:0] nh [5];
		nh = '{8'd43, 8'd44, 8'd50, 8'd51, 8'd60};
		wr(`SQSM_IDX_GLOBAL, 8'h40);
		pk(1'b1, 8'h02, 8'h00, 6'h00);
		chk("igmp_on", 1, res_to_host_o);
		pk(1'b0, 8'd58, 8'h00, 6'h00);
		chk("mld_off", 0, res_to_host_o);
		wr(`SQSM_IDX_GLOBAL, 8'h04);
		pk(1'b1, 8'h02, 8'h00, 6'h00);
		chk("igmp_off", 0, res_to_host_o);
		pk(1'b0, 8'd1, 8'h00, 6'h00);
		chk("mld_1", 1, res_to_host_o);
		pk(1'b0, 8'd0, 8'd58, 6'h00);
		chk("mld_hbh58", 1, res_to_host_o);
		pk(1'b0, 8'd43, 8'h00, 6'h00);
		chk("mld_43_clr", 0, res_to_host_o);
		pk(1'b0, 8'd58, 8'h00, 6'h00);
		chk("mld_58", 1, res_to_host_o);
		wr(`SQSM_IDX_GLOBAL, 8'h0C);
		for (int i = 0; i < 5; i++) begin
			pk(1'b0, nh[i], 8'h00, 6'h00);
			chk("crit_nh", 1, res_to_host_o);
			pk(1'b0, 8'd0, nh[i], 6'h00);
			chk("crit_hbh", 1, res_to_host_o);
		end
		pk(1'b0, 8'd58, 8'h00, 6'h00);
		chk("crit_58", 0, res_to_host_o);
	endtask

	// mirror filter in or-mode then and-mode, all match pairs
	task t_mirror;
		for (int m = 0; m < 2; m++) begin
			wr(`SQSM_IDX_GLOBAL, 8'(m));
			for (int i = 0; i < 4; i++) begin
				pkt_src_match_i <= i[0];
				pkt_dst_match_i <= i[1];
				pk(1'b1, 8'h06, 8'h00, 6'h00);
				chk("mirror", m ? (i == 3) : (i != 0), res_mirror_o);
			end
		end
		pkt_src_match_i <= 1'b0;
		pkt_dst_match_i <= 1'b0;
	endtask

	// timing message priority overrides on and off
	task t_ptp;
		pkt_qos_prio_i <= 4'h3;
		for (int k = 0; k < 2; k++) begin
			wr(`SQSM_IDX_EVT_PRIO, k ? 8'h05 : 8'h85);
			wr(`SQSM_IDX_GEN_PRIO, k ? 8'h0A : 8'h8A);
			pkt_ptp_event_i <= 1'b1;
			pk(1'b1, 8'd17, 8'h00, 6'h00);
			chk("evt_prio", k ? 4'h3 : 4'h5, res_prio_o);
			pkt_ptp_event_i <= 1'b0;
			pkt_ptp_general_i <= 1'b1;
			pk(1'b1, 8'd17, 8'h00, 6'h00);
			chk("gen_prio", k ? 4'h3 : 4'hA, res_prio_o);
			pkt_ptp_general_i <= 1'b0;
		end
	endtask

	// reset in mid-run must bring every register back to its reset value
	task t_rst_mid;
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		t_reset;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		fail_count = 0;
		compares = 0;
		{arst_n_i, address_i, read_i, write_i, byteenable_i} = '0;
		{writedata_i, pkt_valid_i, pkt_ipv4_i, pkt_ipv6_i} = '0;
		{pkt_dscp_i, pkt_proto_i, pkt_hbh_next_i} = '0;
		{pkt_src_match_i, pkt_dst_match_i, pkt_qos_prio_i} = '0;
		{pkt_ptp_event_i, pkt_ptp_general_i} = '0;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		t_reset;
		t_regs;
		t_dscp;
		t_snoop;
		t_mirror;
		t_ptp;
		t_rst_mid;
		test_done;
	end
endmodule // tb_sqsm_regs
